// >>> verilog/dsw_pkg.sv
// package for the drive status word block: register map, status bit positions, defaults
// assumes one 25 MHz clock and a 16-bit holding-register port
package dsw_pkg;
   // ************************************************************
   // geometry and timing
   // ************************************************************
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CLK_HZ = 25000000;
   // ************************************************************
   // register offsets (holding register numbers)
   // ************************************************************
   localparam logic [7:0] OFF_BRAKE_STEPS = 8'h3e;
   localparam logic [7:0] OFF_POS_SPEED = 8'h42;
   localparam logic [7:0] OFF_MAX_CCW = 8'h43;
   localparam logic [7:0] OFF_MAX_CW = 8'h44;
   localparam logic [7:0] OFF_MAN_SPEED = 8'h45;
   localparam logic [7:0] OFF_ACCEL = 8'h47;
   localparam logic [7:0] OFF_DECEL = 8'h48;
   localparam logic [7:0] OFF_START_TORQUE = 8'h4c;
   localparam logic [7:0] OFF_RUN_TORQUE = 8'h4d;
   localparam logic [7:0] OFF_END_TORQUE = 8'h4e;
   localparam logic [7:0] OFF_HOLD_TORQUE = 8'h4f;
   localparam logic [7:0] OFF_VOLT_LIMIT = 8'h68;
   localparam logic [7:0] OFF_TEMP_LIMIT = 8'h69;
   localparam logic [7:0] OFF_STATUS = 8'h70;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h71;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h72;
   // ************************************************************
   // status word bit positions
   // ************************************************************
   localparam int unsigned BIT_TARGET = 0;
   localparam int unsigned BIT_DRAG = 1;
   localparam int unsigned BIT_JOG_REV = 2;
   localparam int unsigned BIT_JOG_FWD = 3;
   localparam int unsigned BIT_POWER = 4;
   localparam int unsigned BIT_ABORT = 5;
   localparam int unsigned BIT_RUNNING = 6;
   localparam int unsigned BIT_OVERTEMP = 7;
   localparam int unsigned BIT_REVERSE = 8;
   localparam int unsigned BIT_ERROR = 9;
   localparam int unsigned NUM_FLAGS = 10;
   // ************************************************************
   // delivery defaults (smallest gear model)
   // ************************************************************
   localparam logic [15:0] DEF_BRAKE_STEPS = 16'h0004;
   localparam logic [15:0] DEF_POS_SPEED = 16'h00e6;
   localparam logic [15:0] DEF_MAX_CCW = 16'h00e6;
   localparam logic [15:0] DEF_MAX_CW = 16'h00e6;
   localparam logic [15:0] DEF_MAN_SPEED = 16'h0050;
   localparam logic [15:0] DEF_ACCEL = 16'h0258;
   localparam logic [15:0] DEF_DECEL = 16'h0258;
   localparam logic [15:0] DEF_START_TORQUE = 16'h007d;
   localparam logic [15:0] DEF_RUN_TORQUE = 16'h0064;
   localparam logic [15:0] DEF_END_TORQUE = 16'h003c;
   localparam logic [15:0] DEF_HOLD_TORQUE = 16'h001e;
   localparam logic [15:0] DEF_VOLT_LIMIT = 16'h00b9;
   localparam logic [15:0] DEF_TEMP_LIMIT = 16'h0046;
   localparam logic [15:0] DEF_ZERO = 16'h0000;
   // ************************************************************
   // limits
   // ************************************************************
   localparam logic [15:0] BRAKE_STEPS_MIN = 16'h0001;
   localparam logic [15:0] BRAKE_STEPS_MAX = 16'h0032;
   localparam logic [15:0] END_TORQUE_MAX = 16'h00b4;
   localparam logic [15:0] VOLT_CEIL = 16'h012c;
   localparam logic [15:0] TEMP_HYST = 16'h0005;
endpackage

// >>> verilog/dsw_status_word.sv
// drive status word generation, parameter registers and event interrupt
// assumes run events arrive as one-cycle pulses from the motion sequencer, levels as synchronous
`timescale 1ns/1ps
module dsw_status_word #(
   parameter int unsigned DATA_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire logic targetReached,
   input wire logic targetInLoopDir,
   input wire logic refLoopDone,
   input wire logic refLoopOk,
   input wire logic actualEqualsTarget,
   input wire logic displacedAtStandstill,
   input wire logic readjustEnable,
   input wire logic errorInWindow,
   input wire logic newTargetOutsideWindow,
   input wire logic manualRun,
   input wire logic manualRunReverse,
   input wire logic invalidTarget,
   input wire logic accelEnd,
   input wire logic maxSpeedReached,
   input wire logic runCommand,
   input wire logic refLoopCommand,
   input wire logic releaseWithdrawnAbort,
   input wire logic positioningReverse,
   input wire logic jogKeyReverse,
   input wire logic jogKeyForward,
   input wire logic [15:0] motorVoltage,
   input wire logic [15:0] temperature,
   input wire logic shaftRotating,
   input wire logic positionCalcFault,
   output logic runAccepted,
   output logic [15:0] statusWord,
   output logic irq
);
   // ************************************************************
   // elaboration check
   // ************************************************************
   if (DATA_W != 16) begin : gBadWidth
      $error("dsw_status_word serves only 16-bit data");
   end

   // ************************************************************
   // parameter register file
   // ************************************************************
   localparam int NPAR = 13;
   localparam logic [7:0] PAR_OFF [NPAR] = '{
      dsw_pkg::OFF_BRAKE_STEPS, dsw_pkg::OFF_POS_SPEED, dsw_pkg::OFF_MAX_CCW,
      dsw_pkg::OFF_MAX_CW, dsw_pkg::OFF_MAN_SPEED, dsw_pkg::OFF_ACCEL, dsw_pkg::OFF_DECEL,
      dsw_pkg::OFF_START_TORQUE, dsw_pkg::OFF_RUN_TORQUE, dsw_pkg::OFF_END_TORQUE,
      dsw_pkg::OFF_HOLD_TORQUE, dsw_pkg::OFF_VOLT_LIMIT, dsw_pkg::OFF_TEMP_LIMIT};
   localparam logic [15:0] PAR_DEF [NPAR] = '{
      dsw_pkg::DEF_BRAKE_STEPS, dsw_pkg::DEF_POS_SPEED, dsw_pkg::DEF_MAX_CCW,
      dsw_pkg::DEF_MAX_CW, dsw_pkg::DEF_MAN_SPEED, dsw_pkg::DEF_ACCEL, dsw_pkg::DEF_DECEL,
      dsw_pkg::DEF_START_TORQUE, dsw_pkg::DEF_RUN_TORQUE, dsw_pkg::DEF_END_TORQUE,
      dsw_pkg::DEF_HOLD_TORQUE, dsw_pkg::DEF_VOLT_LIMIT, dsw_pkg::DEF_TEMP_LIMIT};
   localparam int IDX_BRAKE = 0;
   localparam int IDX_END_TORQUE = 9;
   localparam int IDX_VOLT = 11;
   localparam int IDX_TEMP = 12;

   logic [15:0] par_reg [NPAR];
   logic [NPAR-1:0] parHit;
   logic [NPAR-1:0] parLegal;
   logic [15:0] parRead;
   logic [15:0] parReadAcc [NPAR+1];

   // out-of-range writes are dropped so the motion logic never sees an illegal setting
   wire brakeLegal = (regWrData >= dsw_pkg::BRAKE_STEPS_MIN) &&
      (regWrData <= dsw_pkg::BRAKE_STEPS_MAX);
   wire endTorqueLegal = regWrData <= dsw_pkg::END_TORQUE_MAX;

   assign parReadAcc[0] = dsw_pkg::DEF_ZERO;
   genvar gi;
   for (gi = 0; gi < NPAR; gi++) begin : gPar
      assign parHit[gi] = regAddr == PAR_OFF[gi];
      if (gi == IDX_BRAKE) begin : gBrake
         assign parLegal[gi] = brakeLegal;
      end else if (gi == IDX_END_TORQUE) begin : gEnd
         assign parLegal[gi] = endTorqueLegal;
      end else begin : gAny
         assign parLegal[gi] = 1'b1;
      end
      always_ff @(posedge clk) begin
         if (rst) begin
            par_reg[gi] <= PAR_DEF[gi];
         end else if (regWrite && parHit[gi] && parLegal[gi]) begin
            par_reg[gi] <= regWrData;
         end
      end
      assign parReadAcc[gi+1] = parReadAcc[gi] | (parHit[gi] ? par_reg[gi] : dsw_pkg::DEF_ZERO);
   end
   assign parRead = parReadAcc[NPAR];

   // ************************************************************
   // level flags
   // ************************************************************
   wire [15:0] voltLimit = par_reg[IDX_VOLT];
   wire [15:0] tempLimit = par_reg[IDX_TEMP];
   wire powerOk = (motorVoltage > voltLimit) && (motorVoltage < dsw_pkg::VOLT_CEIL);
   wire tempHigh = temperature > tempLimit;
   // clear point kept in 17 bits so a high temperature cannot wrap
   wire [16:0] tempClearSum = {1'b0, temperature} + {1'b0, dsw_pkg::TEMP_HYST};
   wire tempLow = tempClearSum <= {1'b0, tempLimit};

   // ************************************************************
   // event flags
   // ************************************************************
   logic target_reg, target_next;
   logic drag_reg, drag_next;
   logic abort_reg, abort_next;
   logic overtemp_reg, overtemp_next;
   logic reverse_reg, reverse_next;
   logic error_reg, error_next;
   logic jogRev_reg, jogFwd_reg, power_reg, running_reg;

   // error blocks every run except the reference loop
   wire runOk = runCommand && (!error_reg || refLoopCommand);
   wire targetSet = targetReached || (refLoopDone && actualEqualsTarget) ||
      (readjustEnable && errorInWindow && !displacedAtStandstill);
   wire targetClr = newTargetOutsideWindow || manualRun || invalidTarget ||
      displacedAtStandstill;
   // a fresh clear event wins over a stale set; set otherwise wins over hold
   assign target_next = targetClr ? 1'b0 : (targetSet ? 1'b1 : target_reg);
   wire dragSet = accelEnd && !maxSpeedReached;
   assign drag_next = dragSet ? 1'b1 : (runOk ? 1'b0 : drag_reg);
   assign abort_next = releaseWithdrawnAbort ? 1'b1 : (runOk ? 1'b0 : abort_reg);
   assign overtemp_next = tempHigh ? 1'b1 : (tempLow ? 1'b0 : overtemp_reg);
   wire revSet = (manualRun && manualRunReverse) || positioningReverse;
   wire revClr = (targetReached && targetInLoopDir) || refLoopDone;
   assign reverse_next = revSet ? 1'b1 : (revClr ? 1'b0 : reverse_reg);
   wire errClr = refLoopDone && refLoopOk;
   assign error_next = positionCalcFault ? 1'b1 : (errClr ? 1'b0 : error_reg);

   always_ff @(posedge clk) begin
      if (rst) begin
         target_reg <= 1'b0;
         drag_reg <= 1'b0;
         abort_reg <= 1'b0;
         overtemp_reg <= 1'b0;
         reverse_reg <= 1'b0;
         error_reg <= 1'b0;
      end else begin
         target_reg <= target_next;
         drag_reg <= drag_next;
         abort_reg <= abort_next;
         overtemp_reg <= overtemp_next;
         reverse_reg <= reverse_next;
         error_reg <= error_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         jogRev_reg <= 1'b0;
         jogFwd_reg <= 1'b0;
         power_reg <= 1'b0;
         running_reg <= 1'b0;
      end else begin
         jogRev_reg <= jogKeyReverse;
         jogFwd_reg <= jogKeyForward;
         power_reg <= powerOk;
         running_reg <= shaftRotating;
      end
   end

   wire [15:0] statusNow = {6'h00, error_reg, reverse_reg, overtemp_reg, running_reg,
      abort_reg, power_reg, jogFwd_reg, jogRev_reg, drag_reg, target_reg};

   // ************************************************************
   // interrupt: sticky rising edges of the status flags
   // ************************************************************
   logic [15:0] prevStatus_reg;
   logic [15:0] irqStat_reg, irqStat_next;
   logic [15:0] irqMask_reg;
   wire [15:0] flagRise = statusNow & ~prevStatus_reg;
   wire irqStatWrite = regWrite && (regAddr == dsw_pkg::OFF_IRQ_STATUS);
   wire [15:0] irqClear = irqStatWrite ? regWrData : dsw_pkg::DEF_ZERO;
   // a rise in the cycle of its clear stays set
   assign irqStat_next = (irqStat_reg & ~irqClear) | flagRise;

   always_ff @(posedge clk) begin
      if (rst) begin
         prevStatus_reg <= dsw_pkg::DEF_ZERO;
         irqStat_reg <= dsw_pkg::DEF_ZERO;
         irqMask_reg <= dsw_pkg::DEF_ZERO;
      end else begin
         prevStatus_reg <= statusNow;
         irqStat_reg <= irqStat_next;
         if (regWrite && regAddr == dsw_pkg::OFF_IRQ_MASK) begin
            irqMask_reg <= regWrData;
         end
      end
   end

   // ************************************************************
   // read port and outputs
   // ************************************************************
   // status read only selects data; no flag reacts to it
   wire [15:0] readMux = (regAddr == dsw_pkg::OFF_STATUS) ? statusNow :
      (regAddr == dsw_pkg::OFF_IRQ_STATUS) ? irqStat_reg :
      (regAddr == dsw_pkg::OFF_IRQ_MASK) ? irqMask_reg : parRead;

   always_ff @(posedge clk) begin
      if (rst) begin
         regRdData <= dsw_pkg::DEF_ZERO;
         statusWord <= dsw_pkg::DEF_ZERO;
         irq <= 1'b0;
         runAccepted <= 1'b0;
      end else begin
         regRdData <= regRead ? readMux : dsw_pkg::DEF_ZERO;
         statusWord <= statusNow;
         irq <= |(irqStat_next & irqMask_reg);
         runAccepted <= runOk;
      end
   end
endmodule // dsw_status_word

// >>> dv/dsw_assertions.sv
// checker for the drive status word: event to flag timing and status reads
// assumes flags show two edges after their cause and reads answer one cycle later
`timescale 1ns/1ps
module dsw_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic regRead,
   input wire logic [15:0] regRdData,
   input wire logic [15:0] statusWord,
   input wire logic runCommand,
   input wire logic refLoopCommand,
   input wire logic refLoopDone,
   input wire logic runAccepted,
   input wire logic accelEnd,
   input wire logic maxSpeedReached,
   input wire logic releaseWithdrawnAbort,
   input wire logic positionCalcFault,
   input wire logic invalidTarget,
   input wire logic positioningReverse,
   input wire logic jogKeyReverse,
   input wire logic jogKeyForward,
   input wire logic shaftRotating
);
   // ****
   // edges since reset release, so level mirrors never see reset-time history
   // ****
   logic [1:0] upCnt;
   always_ff @(posedge clk) begin
      if (rst) upCnt <= 2'h0;
      else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_drag;
      accelEnd && !maxSpeedReached;
   endsequence
   sequence s_refused;
      runCommand && statusWord[9] && !refLoopCommand && !$past(refLoopDone);
   endsequence
   property p_drag; s_drag |-> ##2 statusWord[1]; endproperty
   property p_abort; releaseWithdrawnAbort |-> ##2 statusWord[5]; endproperty
   property p_err; positionCalcFault |-> ##2 statusWord[9]; endproperty
   property p_refuse; s_refused |=> !runAccepted; endproperty
   property p_tgt_clr; invalidTarget |-> ##2 !statusWord[0]; endproperty
   property p_rev; positioningReverse |-> ##2 statusWord[8]; endproperty
   property p_jog;
      upCnt == 2'h3 |-> statusWord[3:2] == {$past(jogKeyForward, 2), $past(jogKeyReverse, 2)};
   endproperty
   property p_run; upCnt == 2'h3 |-> statusWord[6] == $past(shaftRotating, 2); endproperty
   property p_rd;
      regRead && regAddr == dsw_pkg::OFF_STATUS |=> regRdData == statusWord;
   endproperty
   a_drag: assert property (p_drag) else $error("drag flag missing");
   a_abort: assert property (p_abort) else $error("abort flag missing");
   a_err: assert property (p_err) else $error("error flag missing");
   a_refuse: assert property (p_refuse) else $error("run accepted in error");
   a_tgt_clr: assert property (p_tgt_clr) else $error("target not cleared");
   a_rev: assert property (p_rev) else $error("reverse flag missing");
   a_jog: assert property (p_jog) else $error("jog flags wrong");
   a_run: assert property (p_run) else $error("running flag wrong");
   a_rd: assert property (p_rd) else $error("status read wrong");
endmodule // dsw_assertions
bind dsw_status_word dsw_assertions u_chk (.clk, .rst, .regAddr, .regRead, .regRdData,
   .statusWord, .runCommand, .refLoopCommand, .refLoopDone, .runAccepted, .accelEnd,
   .maxSpeedReached, .releaseWithdrawnAbort, .positionCalcFault, .invalidTarget,
   .positioningReverse, .jogKeyReverse, .jogKeyForward, .shaftRotating);

// >>> dv/dsw_bus_master.sv
// fieldbus master model: one-cycle holding register writes and reads
// assumes the slave answers a read in the next cycle and never stalls
`timescale 1ns/1ps
module dsw_bus_master (
   input wire logic clk,
   output logic [7:0] regAddr,
   output logic [15:0] regWrData,
   output logic regWrite,
   output logic regRead,
   input wire logic [15:0] regRdData
);
   initial begin
      regAddr = 8'h00;
      regWrData = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so grab them then
   task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      d = regRdData;
   endtask
endmodule // dsw_bus_master

// >>> dv/testbench.sv
// self-checking bench for the drive status word: registers, levels, events, interrupt
// assumes the bus master model and the bound checker sit beside the design
`timescale 1ns/1ps
`define CHK(n, e, a) begin checksDone++; if ((a) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [21:0] ev = 22'h00_0000;
   logic [15:0] motorVoltage = 16'h0000;
   logic [15:0] temperature = 16'h0000;
   logic [7:0] regAddr;
   logic [15:0] regWrData, regRdData, statusWord, rd;
   logic regWrite, regRead, runAccepted, irq;
   int failures = 0;
   int checksDone = 0;
   always #20 clk = ~clk;
   dsw_bus_master u_mst (.clk, .regAddr, .regWrData, .regWrite, .regRead, .regRdData);
   dsw_status_word u_dut (.clk, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
      .targetReached(ev[0]), .targetInLoopDir(ev[1]), .refLoopDone(ev[2]), .refLoopOk(ev[3]),
      .actualEqualsTarget(ev[4]), .displacedAtStandstill(ev[5]), .readjustEnable(ev[6]),
      .errorInWindow(ev[7]), .newTargetOutsideWindow(ev[8]), .manualRun(ev[9]),
      .manualRunReverse(ev[10]), .invalidTarget(ev[11]), .accelEnd(ev[12]),
      .maxSpeedReached(ev[13]), .runCommand(ev[14]), .refLoopCommand(ev[15]),
      .releaseWithdrawnAbort(ev[16]), .positioningReverse(ev[17]), .jogKeyReverse(ev[18]),
      .jogKeyForward(ev[19]), .motorVoltage, .temperature, .shaftRotating(ev[20]),
      .positionCalcFault(ev[21]), .runAccepted, .statusWord, .irq);
   // ****
   // shared steps
   // ****
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      u_mst.read_reg(a, rd);
      `CHK("regRdData", e, rd)
   endtask
   task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
      u_mst.write_reg(a, d);
      rd_chk(a, e);
   endtask
   task automatic ev_step(input logic [21:0] m, input logic [15:0] e);
      @(posedge clk);
      ev <= ev | m;
      @(posedge clk);
      ev <= ev & ~m;
      repeat (2) @(posedge clk);
      #1;
      `CHK("statusWord", e, statusWord)
   endtask
   task automatic lvl_chk(input int b, input logic e);
      repeat (3) @(posedge clk);
      #1;
      `CHK("statusBit", e, statusWord[b])
   endtask
   // runAccepted is a one-cycle pulse, so look right after the edge that takes the command
   task automatic run_chk(input logic [21:0] m, input logic e);
      @(posedge clk);
      ev <= ev | m;
      @(posedge clk);
      ev <= ev & ~m;
      #1;
      `CHK("runAccepted", e, runAccepted)
   endtask
   task automatic give_verdict();
      if (failures == 0 && checksDone > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_regs();
      logic [7:0] offs [13] = '{8'h3e, 8'h42, 8'h43, 8'h44, 8'h45, 8'h47, 8'h48, 8'h4c, 8'h4d,
         8'h4e, 8'h4f, 8'h68, 8'h69};
      logic [15:0] defs [13] = '{16'h0004, 16'h00e6, 16'h00e6, 16'h00e6, 16'h0050, 16'h0258,
         16'h0258, 16'h007d, 16'h0064, 16'h003c, 16'h001e, 16'h00b9, 16'h0046};
      for (int i = 0; i < 13; i++) rd_chk(offs[i], defs[i]);
      wr_rd(8'h3e, 16'h0000, 16'h0004);
      wr_rd(8'h3e, 16'h0033, 16'h0004);
      wr_rd(8'h3e, 16'h0032, 16'h0032);
      wr_rd(8'h3e, 16'h0001, 16'h0001);
      wr_rd(8'h4e, 16'h00b5, 16'h003c);
      wr_rd(8'h4e, 16'h00b4, 16'h00b4);
      rd_chk(8'h50, 16'h0000);
   endtask
   task automatic t_levels();
      logic [15:0] volts [4] = '{16'h0064, 16'h0065, 16'h012b, 16'h012c};
      logic [15:0] temps [4] = '{16'h0046, 16'h0047, 16'h0042, 16'h0041};
      logic hi [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      int jb [3] = '{2, 3, 6};
      u_mst.write_reg(8'h68, 16'h0064);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         motorVoltage <= volts[i];
         temperature <= temps[i];
         lvl_chk(4, hi[i]);
         `CHK("overTemp", hi[i], statusWord[7])
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         ev[18 + i] <= 1'b1;
         lvl_chk(jb[i], 1'b1);
         @(posedge clk);
         ev[18 + i] <= 1'b0;
         lvl_chk(jb[i], 1'b0);
      end
   endtask
   task automatic t_flags();
      ev_step(22'h00_3000, 16'h0000);
      ev_step(22'h00_1000, 16'h0002);
      ev_step(22'h00_4000, 16'h0000);
      ev_step(22'h01_0000, 16'h0020);
      ev_step(22'h00_4000, 16'h0000);
      ev_step(22'h02_0000, 16'h0100);
      ev_step(22'h00_0200, 16'h0100);
      ev_step(22'h00_0003, 16'h0001);
      ev_step(22'h00_0800, 16'h0000);
      ev_step(22'h00_0001, 16'h0001);
      ev_step(22'h00_0100, 16'h0000);
      ev_step(22'h00_0001, 16'h0001);
      ev_step(22'h00_0200, 16'h0000);
      ev_step(22'h00_0001, 16'h0001);
      ev_step(22'h00_0020, 16'h0000);
      ev_step(22'h00_00c0, 16'h0001);
      ev_step(22'h20_0000, 16'h0201);
      ev_step(22'h02_0000, 16'h0301);
      ev_step(22'h01_0000, 16'h0321);
      ev_step(22'h00_4000, 16'h0321);
      ev_step(22'h00_001c, 16'h0021);
      ev_step(22'h00_4000, 16'h0001);
      // old rises are flushed first, so irq can only come from the new drag event
      u_mst.write_reg(8'h71, 16'hffff);
      u_mst.write_reg(8'h72, 16'h0002);
      ev_step(22'h00_1000, 16'h0003);
      `CHK("irq", 1'b1, irq)
      rd_chk(8'h70, 16'h0003);
      `CHK("statusWord", 16'h0003, statusWord)
      u_mst.write_reg(8'h71, 16'h0002);
      repeat (2) @(posedge clk);
      #1;
      `CHK("irq", 1'b0, irq)
      run_chk(22'h00_4000, 1'b1);
      ev_step(22'h20_0000, 16'h0201);
      run_chk(22'h00_4000, 1'b0);
      run_chk(22'h00_c000, 1'b1);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_levels();
      t_flags();
      give_verdict();
   end
   initial begin
      #200000;
      failures++;
      give_verdict();
   end
endmodule // testbench
